// ### logic/pcg_clock_generator.sv
// Behaviour
// - Base clock is half oscillator or prescaled VCO.
// - System clock taken from base or oscillator.
// - Interrupt enable forced zero when manual.
// - Lock flag and lock read zero manually.
// - Filter mode bit read-only in automatic mode.
// - Base select cleared when off or range zero.
// - Programming registers locked while loop powered.
// - Power-on held set while base select set.
// - Centre frequency output is L times 2^E, with no 125kHz step applied.
// - Reference divided by modulo R.
// - VCO divided by 2^P then by N.
// - Phase detector emits up or down pulses.
// - Lock detector compares frequencies, picks mode and lock.
// - Mode switching automatic or manual.
// - Acquisition mode reads filter bit zero.
// - Tracking whenever not acquiring or bit set.
// - Loop reference is buffered oscillator clock.
// - Lock follows tolerance; toggle requests interrupt.
`timescale 1ns/1ps
`default_nettype none
module pcg_clock_generator (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [pcg_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic oscillator_clock,
  input wire logic vco_clock,
  input wire logic system_clock_from_oscillator,
  output logic loop_reference_clock,
  output logic base_clock_out,
  output logic system_clock_source,
  output logic prescaled_vco_clock,
  output logic divided_reference_clock,
  output logic feedback_clock,
  output logic phase_pump_up,
  output logic phase_pump_down,
  output logic filter_tracking,
  output logic loop_enable,
  output logic [15:0] vco_center_khz,
  output logic lock_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for the oscillator and VCO pins.
  logic [1:0] osc_sync;
  logic [1:0] vco_sync;
  logic osc_prev;
  logic vco_prev;
  logic osc_rise;
  logic vco_rise;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_sync <= 2'h0;
      vco_sync <= 2'h0;
      osc_prev <= 1'b0;
      vco_prev <= 1'b0;
    end else begin
      osc_sync <= {osc_sync[0], oscillator_clock};
      vco_sync <= {vco_sync[0], vco_clock};
      osc_prev <= osc_sync[1];
      vco_prev <= vco_sync[1];
    end
  end

  assign osc_rise = osc_sync[1] & ~osc_prev;
  assign vco_rise = vco_sync[1] & ~vco_prev;
  assign loop_reference_clock = osc_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  pcg_pkg::pcg_ctl_s ctl;
  logic lock_change_flag;
  logic automatic_bw;
  logic filter_wide_mode_bit;
  logic lock_state;
  logic [11:0] feedback_modulo_count;
  logic [7:0] vco_linear_factor;
  logic [3:0] reference_divider_value;
  logic [7:0] reg_index;
  logic wr_go;
  logic rd_go, rd_ack;
  logic lock_toggle;
  logic hw_track;

  assign reg_index = 8'(avs_address[pcg_pkg::ADDR_W-1:pcg_pkg::IDX_LSB]);
  assign wr_go = avs_write & avs_byteenable[0];
  assign rd_go = avs_read & ~rd_ack;
  assign avs_waitrequest = rd_go;

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] ofs);
    hit = (idx == ofs);
  endfunction

  logic wr_ctl;
  logic wr_bw;
  logic prog_open;
  logic [7:0] wd;
  assign wd = avs_writedata[7:0];
  assign wr_ctl = wr_go & hit(reg_index, pcg_pkg::OFS_LOOP_CONTROL);
  assign wr_bw = wr_go & hit(reg_index, pcg_pkg::OFS_BANDWIDTH_CONTROL);
  assign prog_open = ~ctl.loop_power_on;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl.lock_interrupt_enable <= pcg_pkg::RST_LOOP_CONTROL[pcg_pkg::BIT_LOCK_IE];
      ctl.loop_power_on <= pcg_pkg::RST_LOOP_CONTROL[pcg_pkg::BIT_POWER_ON];
      ctl.base_clock_select <= pcg_pkg::RST_LOOP_CONTROL[pcg_pkg::BIT_BASE_SEL];
      ctl.feedback_power_divider <= 2'h0;
      ctl.vco_range_exponent <= 2'h0;
    end else begin
      if (wr_ctl) begin
        ctl.feedback_power_divider <= wd[pcg_pkg::BIT_PRE_HI:pcg_pkg::BIT_PRE_LO];
        ctl.vco_range_exponent <= wd[pcg_pkg::BIT_VPR_HI:pcg_pkg::BIT_VPR_LO];
        if (automatic_bw) begin
          ctl.lock_interrupt_enable <= wd[pcg_pkg::BIT_LOCK_IE];
        end
        if (!ctl.base_clock_select) begin
          ctl.loop_power_on <= wd[pcg_pkg::BIT_POWER_ON];
        end
        if (ctl.loop_power_on && vco_linear_factor != 8'h00) begin
          ctl.base_clock_select <= wd[pcg_pkg::BIT_BASE_SEL];
        end
      end
      if (!automatic_bw) begin
        ctl.lock_interrupt_enable <= 1'b0;
      end
      if (!ctl.loop_power_on || vco_linear_factor == 8'h00) begin
        ctl.base_clock_select <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      automatic_bw <= pcg_pkg::RST_BANDWIDTH_CONTROL[pcg_pkg::BIT_AUTO];
      filter_wide_mode_bit <= pcg_pkg::RST_BANDWIDTH_CONTROL[pcg_pkg::BIT_ACQ];
    end else begin
      if (wr_bw) begin
        automatic_bw <= wd[pcg_pkg::BIT_AUTO];
      end
      if (automatic_bw) begin
        filter_wide_mode_bit <= hw_track;
      end else if (wr_bw) begin
        filter_wide_mode_bit <= wd[pcg_pkg::BIT_ACQ];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      feedback_modulo_count <= {pcg_pkg::RST_MUL_HIGH, pcg_pkg::RST_MUL_LOW};
      vco_linear_factor <= pcg_pkg::RST_VCO_RANGE;
      reference_divider_value <= pcg_pkg::RST_REF_DIV;
    end else if (wr_go && prog_open) begin
      if (hit(reg_index, pcg_pkg::OFS_MULTIPLIER_HIGH)) begin
        feedback_modulo_count[11:8] <= wd[3:0];
      end
      if (hit(reg_index, pcg_pkg::OFS_MULTIPLIER_LOW)) begin
        feedback_modulo_count[7:0] <= wd;
      end
      if (hit(reg_index, pcg_pkg::OFS_VCO_RANGE_SELECT)) begin
        vco_linear_factor <= wd;
      end
      if (hit(reg_index, pcg_pkg::OFS_REFERENCE_DIVIDER_SELECT)) begin
        reference_divider_value <= wd[3:0];
      end
    end
  end

  // Lock change flag: hardware set wins over a software clear by reading the loop control register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_change_flag <= 1'b0;
    end else if (!automatic_bw) begin
      lock_change_flag <= 1'b0;
    end else if (lock_toggle) begin
      lock_change_flag <= 1'b1;
    end else if (rd_go && hit(reg_index, pcg_pkg::OFS_LOOP_CONTROL)) begin
      lock_change_flag <= 1'b0;
    end
  end

  assign lock_irq = lock_change_flag & ctl.lock_interrupt_enable;

  // Read multiplexer; a read waits one cycle so its registered data stands at the answer.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
      rd_ack <= 1'b0;
    end else begin
      rd_ack <= rd_go;
      avs_readdata <= 32'h0000_0000;
      if (rd_go) begin
        case (reg_index)
          pcg_pkg::OFS_LOOP_CONTROL: begin
            avs_readdata[7:0] <= {ctl.lock_interrupt_enable,
              lock_change_flag & automatic_bw, ctl.loop_power_on,
              ctl.base_clock_select, ctl.feedback_power_divider,
              ctl.vco_range_exponent};
          end
          pcg_pkg::OFS_BANDWIDTH_CONTROL: begin
            avs_readdata[7:0] <= {automatic_bw, lock_state & automatic_bw,
              filter_wide_mode_bit, 5'h00};
          end
          pcg_pkg::OFS_MULTIPLIER_HIGH: avs_readdata[3:0] <= feedback_modulo_count[11:8];
          pcg_pkg::OFS_MULTIPLIER_LOW: avs_readdata[7:0] <= feedback_modulo_count[7:0];
          pcg_pkg::OFS_VCO_RANGE_SELECT: avs_readdata[7:0] <= vco_linear_factor;
          pcg_pkg::OFS_REFERENCE_DIVIDER_SELECT: avs_readdata[3:0] <= reference_divider_value;
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dividers.
  logic [3:0] ref_cnt;
  logic [7:0] pre_cnt;
  logic [11:0] fb_cnt;
  logic ref_tick;
  logic fb_tick;
  logic pre_tick;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_cnt <= 4'h0;
      divided_reference_clock <= 1'b0;
    end else begin
      divided_reference_clock <= 1'b0;
      if (osc_rise) begin
        if (ref_cnt + 4'h1 >= reference_divider_value) begin
          ref_cnt <= 4'h0;
          divided_reference_clock <= 1'b1;
        end else begin
          ref_cnt <= ref_cnt + 4'h1;
        end
      end
    end
  end
  assign ref_tick = divided_reference_clock;

  assign pre_tick = vco_rise &&
    ((pre_cnt & 8'((1 << ctl.feedback_power_divider) - 1)) == 8'h00);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt <= 8'h00;
      prescaled_vco_clock <= 1'b0;
    end else begin
      if (vco_rise) begin
        pre_cnt <= pre_cnt + 8'h01;
      end
      if (pre_tick) begin
        prescaled_vco_clock <= ~prescaled_vco_clock;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fb_cnt <= 12'h000;
      feedback_clock <= 1'b0;
    end else begin
      feedback_clock <= 1'b0;
      if (pre_tick) begin
        if (fb_cnt + 12'h001 >= feedback_modulo_count) begin
          fb_cnt <= 12'h000;
          feedback_clock <= 1'b1;
        end else begin
          fb_cnt <= fb_cnt + 12'h001;
        end
      end
    end
  end
  assign fb_tick = feedback_clock;

  ////////////////////////////////////////////////////////////////////////////
  // Phase detector: pump up from reference edge to feedback edge and back.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_pump_up <= 1'b0;
      phase_pump_down <= 1'b0;
    end else if (!ctl.loop_power_on || (ref_tick && fb_tick)) begin
      phase_pump_up <= 1'b0;
      phase_pump_down <= 1'b0;
    end else if (ref_tick) begin
      phase_pump_up <= ~phase_pump_down;
      phase_pump_down <= 1'b0;
    end else if (fb_tick) begin
      phase_pump_down <= ~phase_pump_up;
      phase_pump_up <= 1'b0;
    end
  end

  // Lock detector counts feedback edges within each reference period.
  logic [15:0] fb_per_ref;
  logic [15:0] err;
  pcg_pkg::pcg_mode_e mode;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fb_per_ref <= 16'h0000;
      lock_state <= 1'b0;
      mode <= pcg_pkg::PCG_ACQUIRE;
    end else if (!ctl.loop_power_on) begin
      fb_per_ref <= 16'h0000;
      lock_state <= 1'b0;
      mode <= pcg_pkg::PCG_ACQUIRE;
    end else if (ref_tick) begin
      fb_per_ref <= 16'(fb_tick);
      lock_state <= (err <= pcg_pkg::LOCK_TOL);
      case (mode)
        pcg_pkg::PCG_ACQUIRE: if (err <= pcg_pkg::LOCK_TOL) mode <= pcg_pkg::PCG_TRACK;
        pcg_pkg::PCG_TRACK: if (err > pcg_pkg::ACQ_TOL) mode <= pcg_pkg::PCG_ACQUIRE;
        default: mode <= pcg_pkg::PCG_ACQUIRE;
      endcase
    end else if (fb_tick) begin
      fb_per_ref <= fb_per_ref + 16'h0001;
    end
  end
  // Error is the distance from one feedback edge per reference period; zero to two edges lock.
  assign err = (fb_per_ref > 16'h0001) ? fb_per_ref - 16'h0001 : 16'h0001 - fb_per_ref;
  assign hw_track = (mode == pcg_pkg::PCG_TRACK);

  logic lock_prev;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_prev <= 1'b0;
    end else begin
      lock_prev <= lock_state;
    end
  end
  assign lock_toggle = automatic_bw & (lock_state ^ lock_prev);

  ////////////////////////////////////////////////////////////////////////////
  // Base clock selector and outputs.
  logic osc_half;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_half <= 1'b0;
      base_clock_out <= 1'b0;
    end else begin
      if (osc_rise) begin
        osc_half <= ~osc_half;
      end
      if (ctl.base_clock_select) begin
        base_clock_out <= prescaled_vco_clock;
      end else begin
        base_clock_out <= osc_half;
      end
    end
  end

  // Low selects the base clock; high selects the oscillator directly.
  assign system_clock_source = system_clock_from_oscillator ? osc_sync[1] : base_clock_out;
  assign filter_tracking = ~filter_wide_mode_bit ? 1'b0 : 1'b1;
  assign loop_enable = ctl.loop_power_on;
  assign vco_center_khz = 16'(32'(vco_linear_factor) << ctl.vco_range_exponent);

endmodule
`default_nettype wire

// ### logic/pcg_pkg.sv
package pcg_pkg;

  // Register offsets, the byte address is four times the index.
  localparam logic [7:0] OFS_LOOP_CONTROL = 8'h36;
  localparam logic [7:0] OFS_BANDWIDTH_CONTROL = 8'h37;
  localparam logic [7:0] OFS_MULTIPLIER_HIGH = 8'h38;
  localparam logic [7:0] OFS_MULTIPLIER_LOW = 8'h39;
  localparam logic [7:0] OFS_VCO_RANGE_SELECT = 8'h3A;
  localparam logic [7:0] OFS_REFERENCE_DIVIDER_SELECT = 8'h3B;
  localparam int ADDR_W = 10;
  localparam int IDX_LSB = 2;

  // Loop control fields.
  localparam int BIT_LOCK_IE = 7;
  localparam int BIT_LOCK_CHG = 6;
  localparam int BIT_POWER_ON = 5;
  localparam int BIT_BASE_SEL = 4;
  localparam int BIT_PRE_HI = 3;
  localparam int BIT_PRE_LO = 2;
  localparam int BIT_VPR_HI = 1;
  localparam int BIT_VPR_LO = 0;
  // Bandwidth control fields.
  localparam int BIT_AUTO = 7;
  localparam int BIT_LOCK = 6;
  localparam int BIT_ACQ = 5;

  // Reset values.
  localparam logic [7:0] RST_LOOP_CONTROL = 8'h20;
  localparam logic [7:0] RST_BANDWIDTH_CONTROL = 8'h00;
  localparam logic [3:0] RST_MUL_HIGH = 4'h0;
  localparam logic [7:0] RST_MUL_LOW = 8'h40;
  localparam logic [7:0] RST_VCO_RANGE = 8'h40;
  localparam logic [3:0] RST_REF_DIV = 4'h1;

  // Nominal centre frequency step of the VCO in kHz.
  localparam int F_NOM_KHZ = 125;
  // Lock tolerance in feedback cycles per reference period.
  localparam logic [15:0] LOCK_TOL = 16'h0001;
  localparam logic [15:0] ACQ_TOL = 16'h0004;

  typedef enum logic [1:0] {
    PCG_ACQUIRE = 2'b01,
    PCG_TRACK = 2'b10
  } pcg_mode_e;

  typedef struct packed {
    logic lock_interrupt_enable;
    logic loop_power_on;
    logic base_clock_select;
    logic [1:0] feedback_power_divider;
    logic [1:0] vco_range_exponent;
  } pcg_ctl_s;

endpackage

// ### bench/pcg_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [pcg_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic system_clock_from_oscillator,
  input wire logic base_clock_out,
  input wire logic system_clock_source,
  input wire logic divided_reference_clock,
  input wire logic feedback_clock,
  input wire logic filter_tracking,
  input wire logic loop_enable,
  input wire logic [15:0] vco_center_khz,
  input wire logic lock_irq
);
  logic auto_sh;
  logic [1:0] age;
  logic bwc_wr;
  logic ctl_wr;
  assign bwc_wr = avs_write && avs_byteenable[0] && avs_address[9:2] == pcg_pkg::OFS_BANDWIDTH_CONTROL;
  assign ctl_wr = avs_write && avs_byteenable[0] && avs_address[9:2] == pcg_pkg::OFS_LOOP_CONTROL;
  // Shadow of the automatic bandwidth bit, which is always writable.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) auto_sh <= 1'b0;
    else if (bwc_wr) auto_sh <= avs_writedata[pcg_pkg::BIT_AUTO];
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_bwc_manual;
    bwc_wr && !auto_sh && !avs_writedata[pcg_pkg::BIT_AUTO];
  endsequence
  sequence s_power_off_wr;
    ctl_wr && !avs_writedata[pcg_pkg::BIT_POWER_ON];
  endsequence
  property p_acq_manual;
    s_bwc_manual |=> filter_tracking == $past(avs_writedata[pcg_pkg::BIT_ACQ]);
  endproperty
  a_acq_manual: assert property (p_acq_manual)
    else $error("filter mode not taken from a manual write");
  property p_irq_auto;
    lock_irq |-> auto_sh;
  endproperty
  a_irq_auto: assert property (p_irq_auto)
    else $error("lock interrupt raised in manual mode");
  property p_sys_mux;
    !system_clock_from_oscillator |-> system_clock_source == base_clock_out;
  endproperty
  a_sys_mux: assert property (p_sys_mux)
    else $error("system clock not taken from the base clock");
  property p_ref_pulse;
    divided_reference_clock |=> !divided_reference_clock;
  endproperty
  a_ref_pulse: assert property (p_ref_pulse)
    else $error("divided reference pulse longer than one cycle");
  property p_fb_pulse;
    feedback_clock |=> !feedback_clock;
  endproperty
  a_fb_pulse: assert property (p_fb_pulse)
    else $error("feedback pulse longer than one cycle");
  property p_center_locked;
    age == 2'h3 && $changed(vco_center_khz) |-> !$past(loop_enable);
  endproperty
  a_center_locked: assert property (p_center_locked)
    else $error("centre frequency changed while the loop was on");
  property p_off_by_write;
    age == 2'h3 && $fell(loop_enable) |-> $past(ctl_wr && !avs_writedata[pcg_pkg::BIT_POWER_ON]);
  endproperty
  a_off_by_write: assert property (p_off_by_write)
    else $error("loop switched off without a write");
  property p_no_wait;
    avs_write |-> !avs_waitrequest;
  endproperty
  a_no_wait: assert property (p_no_wait)
    else $error("write was made to wait");
  property p_read_wait;
    age == 2'h3 && avs_read && !$past(avs_read) |-> avs_waitrequest;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read answered without its wait state");
  c_power_off: cover property (s_power_off_wr);
endmodule
bind pcg_clock_generator pcg_chk u_pcg_chk (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .system_clock_from_oscillator(system_clock_from_oscillator),
  .base_clock_out(base_clock_out), .system_clock_source(system_clock_source),
  .divided_reference_clock(divided_reference_clock), .feedback_clock(feedback_clock),
  .filter_tracking(filter_tracking), .loop_enable(loop_enable),
  .vco_center_khz(vco_center_khz), .lock_irq(lock_irq));
`default_nettype wire

// ### bench/pcg_sim_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_sim_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic base_clock_out,
  input wire logic use_oscillator,
  output logic system_clock_from_oscillator,
  output logic [15:0] base_edges
);
  logic base_d;
  // The integration side picks its source and counts base clock rises.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      system_clock_from_oscillator <= 1'b0;
      base_d <= 1'b0;
      base_edges <= 16'h0000;
    end else begin
      system_clock_from_oscillator <= use_oscillator;
      base_d <= base_clock_out;
      if (base_clock_out && !base_d) base_edges <= base_edges + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ### bench/pcg_clock_generator_test.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_clock_generator_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [pcg_pkg::ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, oscillator_clock = 1'b0, vco_clock = 1'b0, use_osc = 1'b0;
  logic loop_reference_clock, base_clock_out, system_clock_source, prescaled_vco_clock;
  logic divided_reference_clock, feedback_clock, phase_pump_up, phase_pump_down;
  logic filter_tracking, loop_enable, lock_irq, sys_from_osc;
  logic [15:0] vco_center_khz, base_edges, snap;
  logic [31:0] lfsr_state = 32'h374A;
  logic [7:0] osc_cnt = 8'h00, vco_cnt = 8'h00, l;
  logic [7:0] ofs_t [6] = '{8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B};
  logic [7:0] rst_t [6] = '{8'h20, 8'h00, 8'h00, 8'h40, 8'h40, 8'h01};
  logic [15:0] exp_q [$];
  int errors = 0;
  int comparisons = 0;

  always #2 clk = ~clk;
  // Slow oscillator and VCO stand-ins, both well below the bus clock.
  always @(posedge clk) begin
    osc_cnt <= (osc_cnt == 8'h09) ? 8'h00 : osc_cnt + 8'h01;
    vco_cnt <= (vco_cnt == 8'h02) ? 8'h00 : vco_cnt + 8'h01;
    if (osc_cnt == 8'h09) oscillator_clock <= ~oscillator_clock;
    if (vco_cnt == 8'h02) vco_clock <= ~vco_clock;
  end

  pcg_clock_generator u_pcg_clock_generator (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .oscillator_clock(oscillator_clock), .vco_clock(vco_clock),
    .system_clock_from_oscillator(sys_from_osc), .loop_reference_clock(loop_reference_clock),
    .base_clock_out(base_clock_out), .system_clock_source(system_clock_source),
    .prescaled_vco_clock(prescaled_vco_clock), .divided_reference_clock(divided_reference_clock),
    .feedback_clock(feedback_clock), .phase_pump_up(phase_pump_up),
    .phase_pump_down(phase_pump_down), .filter_tracking(filter_tracking),
    .loop_enable(loop_enable), .vco_center_khz(vco_center_khz), .lock_irq(lock_irq));
  pcg_sim_model u_pcg_sim_model (.clk(clk), .rst_b(rst_b), .base_clock_out(base_clock_out),
    .use_oscillator(use_osc), .system_clock_from_oscillator(sys_from_osc),
    .base_edges(base_edges));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // The request stands until waitrequest is sampled low, then it is released.
  task automatic bus(input logic [7:0] ofs, input logic wr, input logic [7:0] d);
    avs_address <= {ofs, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    bus(ofs, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] ofs, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({m, e});
    bus(ofs, 1'b0, 8'h00);
  endtask
  // Read monitor compares the data of each answered read with the oldest note.
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      check(avs_readdata & {24'h0, exp_q[0][15:8]}, {24'h0, exp_q[0][7:0]});
      exp_q.delete(0);
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check(loop_enable, 1'b1);
    for (int i = 0; i < 6; i++) rd(ofs_t[i], rst_t[i], (i == 1) ? 8'hFE : 8'hFF);
    rd(8'h3C, 8'h00, 8'hFF);
    for (int i = 2; i < 6; i++) begin
      lfsr_state = lfsr(lfsr_state);
      wr(ofs_t[i], lfsr_state[7:0]);
      rd(ofs_t[i], rst_t[i], 8'hFF);
    end
    wr(8'h36, 8'h30);
    rd(8'h36, 8'h30, 8'hFF);
    wr(8'h36, 8'h00);
    rd(8'h36, 8'h20, 8'hFF);
    wr(8'h36, 8'h20);
    wr(8'h36, 8'h00);
    check(loop_enable, 1'b0);
    wr(8'h36, 8'h10);
    rd(8'h36, 8'h00, 8'hFF);
    for (int e = 0; e < 3; e++) begin
      lfsr_state = lfsr(lfsr_state);
      l = lfsr_state[7:0];
      wr(8'h3A, l);
      wr(8'h36, e[7:0]);
      rd(8'h3A, l, 8'hFF);
      check(vco_center_khz, {8'h00, l} << e);
    end
    wr(8'h38, lfsr_state[15:8]);
    rd(8'h38, lfsr_state[15:8] & 8'h0F, 8'hFF);
    wr(8'h3B, lfsr_state[23:16]);
    rd(8'h3B, lfsr_state[23:16] & 8'h0F, 8'hFF);
    wr(8'h38, 8'h00);
    wr(8'h39, 8'h01);
    wr(8'h3B, 8'h01);
    wr(8'h3A, 8'h00);
    wr(8'h36, 8'h20);
    wr(8'h36, 8'h30);
    rd(8'h36, 8'h20, 8'hFF);
    wr(8'h36, 8'h00);
    wr(8'h3A, 8'h40);
    wr(8'h37, 8'h20);
    rd(8'h37, 8'h20, 8'hFE);
    check(filter_tracking, 1'b1);
    wr(8'h37, 8'h00);
    check(filter_tracking, 1'b0);
    wr(8'h36, 8'h80);
    rd(8'h36, 8'h00, 8'hFF);
    check(lock_irq, 1'b0);
    wr(8'h37, 8'h80);
    wr(8'h36, 8'h80);
    rd(8'h36, 8'h80, 8'h80);
    wr(8'h37, 8'h00);
    rd(8'h36, 8'h00, 8'hC0);
    wr(8'h36, 8'h20);
    @(posedge clk);
    snap = base_edges;
    repeat (400) @(posedge clk);
    check((base_edges - snap) inside {[16'd9 : 16'd11]}, 1'b1);
    use_osc <= 1'b1;
    repeat (200) @(posedge clk);
    check(sys_from_osc, 1'b1);
    while (osc_cnt != 8'h05) @(posedge clk);
    check(system_clock_source, oscillator_clock);
    check(loop_reference_clock, oscillator_clock);
    // Automatic mode with about one feedback pulse per reference period locks.
    wr(8'h36, 8'h00);
    wr(8'h39, 8'h03);
    wr(8'h37, 8'h80);
    wr(8'h36, 8'hA0);
    repeat (60) @(posedge clk);
    check(lock_irq, 1'b1);
    rd(8'h37, 8'hE0, 8'hFF);
    wr(8'h37, 8'h80);
    check(filter_tracking, 1'b1);
    rd(8'h36, 8'hE0, 8'hFF);
    check(lock_irq, 1'b0);
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out;
  end
endmodule
`default_nettype wire
